// *** pkg/dsg_pkg.sv ***
// Package: offsets, field layout, reset values and types of the gate control
package dsg_pkg;

  // ==========================================================================
  // Register map (byte offsets inside the system control block)
  localparam logic [31:0] DSG_BASE_ADDR      = 32'h400F_E000;
  localparam int unsigned DSG_ADDR_W         = 12;
  localparam logic [11:0] DSG_OFS_RUN_CFG    = 12'h060;
  localparam logic [11:0] DSG_OFS_RUN_GATE   = 12'h104;
  localparam logic [11:0] DSG_OFS_SLEEP_GATE = 12'h114;
  localparam logic [11:0] DSG_OFS_DEEP_GATE  = 12'h124;
  localparam logic [11:0] DSG_OFS_IRQ_STATUS = 12'h200;
  localparam logic [11:0] DSG_OFS_IRQ_CLEAR  = 12'h204;
  localparam logic [11:0] DSG_OFS_IRQ_ENABLE = 12'h208;
  localparam logic [11:0] DSG_OFS_FAULT_INFO = 12'h20C;

  // ==========================================================================
  // Field positions of the gating, config and interrupt registers, and the unit count
  localparam int unsigned DSG_BIT_COMP_B  = 25;
  localparam int unsigned DSG_BIT_COMP_A  = 24;
  localparam int unsigned DSG_BIT_CNT_C   = 18;
  localparam int unsigned DSG_BIT_CNT_B   = 17;
  localparam int unsigned DSG_BIT_CNT_A   = 16;
  localparam int unsigned DSG_BIT_SYNC    = 4;
  localparam int unsigned DSG_BIT_ASYNC   = 0;
  localparam int unsigned DSG_BIT_AUTO    = 0;
  localparam int unsigned DSG_IRQ_FAULT   = 0;
  localparam int unsigned DSG_IRQ_MODE    = 1;
  localparam int unsigned DSG_IRQ_W       = 2;
  localparam int unsigned DSG_UNITS       = 7;

  // ==========================================================================
  // Masks and reset values
  localparam logic [31:0] DSG_GATE_WMASK  = 32'h0307_0011;
  localparam logic [31:0] DSG_GATE_RESET  = 32'h0000_0000;
  localparam logic        DSG_AUTO_RESET  = 1'b0;
  localparam logic [1:0]  DSG_IRQ_RESET   = 2'h0;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic comp_b;
    logic comp_a;
    logic cnt_c;
    logic cnt_b;
    logic cnt_a;
    logic sync_ser;
    logic async_ser;
  } dsg_units_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dsg_bus_req_t;

  typedef enum logic [2:0] {
    DSG_MODE_RUN   = 3'b001,
    DSG_MODE_SLEEP = 3'b010,
    DSG_MODE_DEEP  = 3'b100
  } dsg_mode_t;

  // ==========================================================================
  // Field conversion between register image and unit vector
  function automatic dsg_units_t dsg_reg_to_units(input logic [31:0] r);
    dsg_units_t u;
    u.comp_b    = r[DSG_BIT_COMP_B];
    u.comp_a    = r[DSG_BIT_COMP_A];
    u.cnt_c     = r[DSG_BIT_CNT_C];
    u.cnt_b     = r[DSG_BIT_CNT_B];
    u.cnt_a     = r[DSG_BIT_CNT_A];
    u.sync_ser  = r[DSG_BIT_SYNC];
    u.async_ser = r[DSG_BIT_ASYNC];
    return u;
  endfunction : dsg_reg_to_units

endpackage : dsg_pkg

// *** rtl/dsg_reset_sync.sv ***
// Reset release synchroniser: asynchronous assert, two-flop release
`timescale 1ns/10ps
`default_nettype none
module dsg_reset_sync
  import dsg_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rstn_in,
  output var  logic rst_n_out
);

  logic meta_reg;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg  <= 1'b0;
      rst_n_out <= 1'b0;
    end else begin
      meta_reg  <= 1'b1;
      rst_n_out <= meta_reg;
    end
  end

endmodule : dsg_reset_sync
`default_nettype wire

// *** rtl/dsg_fault_chk.sv ***
// Access checker: flags a unit access while that unit's clock is off
`timescale 1ns/10ps
`default_nettype none
module dsg_fault_chk
  import dsg_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire dsg_units_t access_in,
  input  wire dsg_units_t clk_en_in,
  output var  logic       fault_out,
  output var  logic [6:0] unit_out
);

  wire dsg_units_t blocked_w = access_in & ~clk_en_in;
  wire logic       any_w     = |blocked_w;

  // Fault flag high one cycle after each cycle of blocked access, unit vector held until the next fault
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_out <= 1'b0;
      unit_out  <= 7'h00;
    end else begin
      fault_out <= any_w;                                     // [RULE4]
      if (any_w) begin
        unit_out <= blocked_w;
      end
    end
  end

  property p_fault_on_gated;
    @(posedge clk_in) disable iff (!rst_n_in)
      |(access_in & ~clk_en_in) |=> fault_out;
  endproperty
  a_fault_on_gated: assert property (p_fault_on_gated)        // [RULE4]
    else $error("access to gated unit gave no fault");

  property p_no_fault_when_clocked;
    @(posedge clk_in) disable iff (!rst_n_in)
      !(|(access_in & ~clk_en_in)) |=> !fault_out;
  endproperty
  a_no_fault_when_clocked: assert property (p_no_fault_when_clocked) // [RULE2]
    else $error("fault raised for clocked unit");

endmodule : dsg_fault_chk
`default_nettype wire

// *** rtl/dsg_gate_ctl.sv ***
// Top: per-unit clock gating control for run, sleep and deep-sleep modes
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Operation
// (RULE1) Each gated unit has its own enable bit: 25, 24, 18..16, 4 and 0.
// (RULE2) A set enable bit delivers the clock enable to its unit.
// (RULE3) A clear enable bit stops the clock enable to its unit.
// (RULE4) An access to a unit whose clock is off is answered with a fault.
// (RULE5) Reset clears every enable bit so the register reads all zeros.
// (RULE6) Software sets the enables of each unit it needs before using it.
// (RULE7) Run, sleep and deep-sleep modes each apply their own gate register.
// (RULE8) Sleep and deep-sleep registers apply only while auto gating is set.
// (RULE9) Reserved bits read as zero and software preserves them.
// (RULE10) The deep-sleep gating register decodes at offset 0x124.
// (RULE11) Writes change only enable bits; reserved bits stay zero.
module dsg_gate_ctl
  import dsg_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire dsg_bus_req_t bus_req_in,
  output var  logic [31:0]  rdata_out,
  input  wire logic         sleep_req_in,
  input  wire logic         deep_sleep_req_in,
  input  wire dsg_units_t   unit_access_in,
  output var  dsg_units_t   unit_clk_en_out,
  output var  logic         bus_fault_out,
  output var  dsg_mode_t    mode_out,
  output var  logic         irq_out
);

  // ==========================================================================
  // Reset
  logic rst_n;

  dsg_reset_sync u_rst (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .rst_n_out (rst_n)
  );

  // ==========================================================================
  // Register state
  logic [31:0]          run_gate_reg;
  logic [31:0]          sleep_gate_reg;
  logic [31:0]          deep_gate_reg;
  logic                 auto_gate_reg;
  logic [DSG_IRQ_W-1:0] irq_status_reg;
  logic [DSG_IRQ_W-1:0] irq_enable_reg;
  logic [6:0]           fault_unit_reg;
  dsg_mode_t            mode_reg;
  dsg_mode_t            mode_next;

  // ==========================================================================
  // Address decode
  wire logic [11:0] addr_w     = bus_req_in.addr;
  wire logic        wr_w       = bus_req_in.wr;
  wire logic        rd_w       = bus_req_in.rd;
  wire logic        hit_cfg    = addr_w == DSG_OFS_RUN_CFG;
  wire logic        hit_run    = addr_w == DSG_OFS_RUN_GATE;
  wire logic        hit_sleep  = addr_w == DSG_OFS_SLEEP_GATE;
  wire logic        hit_deep   = addr_w == DSG_OFS_DEEP_GATE;   // [RULE10]
  wire logic        hit_status = addr_w == DSG_OFS_IRQ_STATUS;
  wire logic        hit_clear  = addr_w == DSG_OFS_IRQ_CLEAR;
  wire logic        hit_enable = addr_w == DSG_OFS_IRQ_ENABLE;
  wire logic        hit_info   = addr_w == DSG_OFS_FAULT_INFO;

  // Reserved bits are never stored, so they always read back as zero
  wire logic [31:0] gate_wdata = bus_req_in.wdata & DSG_GATE_WMASK; // [RULE11]

  // ==========================================================================
  // Gating registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      run_gate_reg   <= DSG_GATE_RESET;
      sleep_gate_reg <= DSG_GATE_RESET;
      deep_gate_reg  <= DSG_GATE_RESET;                        // [RULE5]
      auto_gate_reg  <= DSG_AUTO_RESET;
    end else if (wr_w) begin
      if (hit_run) begin
        run_gate_reg <= gate_wdata;
      end
      if (hit_sleep) begin
        sleep_gate_reg <= gate_wdata;
      end
      if (hit_deep) begin
        deep_gate_reg <= gate_wdata;                           // [RULE1]
      end
      if (hit_cfg) begin
        auto_gate_reg <= bus_req_in.wdata[DSG_BIT_AUTO];
      end
    end
  end

  // ==========================================================================
  // Operating mode; deep-sleep takes precedence over sleep
  always_comb begin
    mode_next = DSG_MODE_RUN;
    if (auto_gate_reg && deep_sleep_req_in) begin
      mode_next = DSG_MODE_DEEP;                               // [RULE8]
    end else if (auto_gate_reg && sleep_req_in) begin
      mode_next = DSG_MODE_SLEEP;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= DSG_MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ==========================================================================
  // Gate selection by mode
  logic [31:0] gate_sel;

  always_comb begin
    unique case (mode_reg)
      DSG_MODE_RUN:   gate_sel = run_gate_reg;                 // [RULE7]
      DSG_MODE_SLEEP: gate_sel = sleep_gate_reg;
      DSG_MODE_DEEP:  gate_sel = deep_gate_reg;
      default:        gate_sel = DSG_GATE_RESET;
    endcase
  end

  wire dsg_units_t gate_units = dsg_reg_to_units(gate_sel);

  // Registered enables keep the outputs glitch free; a change lands one
  // cycle after the mode or register update
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      unit_clk_en_out <= '0;
      mode_out        <= DSG_MODE_RUN;
    end else begin
      unit_clk_en_out <= gate_units;                           // [RULE2] [RULE3]
      mode_out        <= mode_reg;
    end
  end

  // ==========================================================================
  // Fault detection against the enables currently applied
  logic       fault_pulse;
  logic [6:0] fault_units;

  dsg_fault_chk u_fault (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n),
    .access_in (unit_access_in),
    .clk_en_in (unit_clk_en_out),
    .fault_out (fault_pulse),
    .unit_out  (fault_units)
  );

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bus_fault_out  <= 1'b0;
      fault_unit_reg <= 7'h00;
    end else begin
      bus_fault_out  <= fault_pulse;                           // [RULE4]
      fault_unit_reg <= fault_units;
    end
  end

  // ==========================================================================
  // Interrupt status: an event in the clear cycle wins over the clear
  wire logic [DSG_IRQ_W-1:0] irq_event;
  assign irq_event[DSG_IRQ_FAULT] = fault_pulse;
  assign irq_event[DSG_IRQ_MODE]  = mode_next != mode_reg;

  wire logic [DSG_IRQ_W-1:0] irq_clear =
    (wr_w && hit_clear) ? bus_req_in.wdata[DSG_IRQ_W-1:0] : DSG_IRQ_RESET;

  wire logic [DSG_IRQ_W-1:0] irq_status_next =
    (irq_status_reg & ~irq_clear) | irq_event;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= DSG_IRQ_RESET;
      irq_enable_reg <= DSG_IRQ_RESET;
      irq_out        <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_w && hit_enable) begin
        irq_enable_reg <= bus_req_in.wdata[DSG_IRQ_W-1:0];
      end
      irq_out <= |(irq_status_next & irq_enable_reg);
    end
  end

  // ==========================================================================
  // Read path: data stand only in the cycle after the strobe
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cfg) begin
      rd_mux[DSG_BIT_AUTO] = auto_gate_reg;
    end else if (hit_run) begin
      rd_mux = run_gate_reg;
    end else if (hit_sleep) begin
      rd_mux = sleep_gate_reg;
    end else if (hit_deep) begin
      rd_mux = deep_gate_reg;                                  // [RULE9]
    end else if (hit_status) begin
      rd_mux[DSG_IRQ_W-1:0] = irq_status_reg;
    end else if (hit_enable) begin
      rd_mux[DSG_IRQ_W-1:0] = irq_enable_reg;
    end else if (hit_info) begin
      rd_mux[6:0] = fault_unit_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= rd_w ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Checks
  property p_deep_reset;
    @(posedge clk_in) $rose(rst_n) |-> deep_gate_reg == DSG_GATE_RESET;
  endproperty
  a_deep_reset: assert property (p_deep_reset)                 // [RULE5]
    else $error("deep-sleep enables not clear after reset");

  property p_reserved_zero;
    @(posedge clk_in) disable iff (!rst_n)
      (deep_gate_reg & ~DSG_GATE_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)           // [RULE9]
    else $error("reserved deep-sleep bit is set");

  property p_deep_write;
    @(posedge clk_in) disable iff (!rst_n)
      (wr_w && addr_w == DSG_OFS_DEEP_GATE) |=>
        deep_gate_reg == ($past(bus_req_in.wdata) & DSG_GATE_WMASK);
  endproperty
  a_deep_write: assert property (p_deep_write)                 // [RULE11]
    else $error("deep-sleep write not stored as masked");

  property p_deep_read;
    @(posedge clk_in) disable iff (!rst_n)
      (rd_w && addr_w == DSG_OFS_DEEP_GATE) |=>
        rdata_out == $past(deep_gate_reg);
  endproperty
  a_deep_read: assert property (p_deep_read)                   // [RULE10]
    else $error("deep-sleep register read back wrong");

  property p_deep_clock_on;
    @(posedge clk_in) disable iff (!rst_n)
      (mode_reg == DSG_MODE_DEEP && deep_gate_reg[DSG_BIT_CNT_A]) |=>
        unit_clk_en_out.cnt_a;
  endproperty
  a_deep_clock_on: assert property (p_deep_clock_on)           // [RULE2]
    else $error("enabled unit not clocked in deep-sleep");

  property p_deep_clock_off;
    @(posedge clk_in) disable iff (!rst_n)
      (mode_reg == DSG_MODE_DEEP && !deep_gate_reg[DSG_BIT_COMP_B]) |=>
        !unit_clk_en_out.comp_b;
  endproperty
  a_deep_clock_off: assert property (p_deep_clock_off)         // [RULE3]
    else $error("disabled unit still clocked in deep-sleep");

  property p_run_selects;
    @(posedge clk_in) disable iff (!rst_n)
      (!auto_gate_reg ##1 1'b1) |=>
        unit_clk_en_out == dsg_reg_to_units($past(run_gate_reg));
  endproperty
  a_run_selects: assert property (p_run_selects)               // [RULE8]
    else $error("sleep gating used without auto gating");

  property p_mode_follow;
    @(posedge clk_in) disable iff (!rst_n)
      (auto_gate_reg && sleep_req_in && !deep_sleep_req_in) |=>
        mode_reg == DSG_MODE_SLEEP ##1 mode_out == DSG_MODE_SLEEP;
  endproperty
  a_mode_follow: assert property (p_mode_follow)               // [RULE7]
    else $error("sleep request did not select sleep gating");

  property p_fault_reaches_port;
    @(posedge clk_in) disable iff (!rst_n)
      |(unit_access_in & ~unit_clk_en_out) |=> ##1 bus_fault_out;
  endproperty
  a_fault_reaches_port: assert property (p_fault_reaches_port) // [RULE4]
    else $error("gated access fault missing at port");

  property p_read_idle_zero;
    @(posedge clk_in) disable iff (!rst_n)
      !rd_w |=> rdata_out == 32'h0000_0000;
  endproperty
  a_read_idle_zero: assert property (p_read_idle_zero)
    else $error("read data present without read strobe");

  property p_deep_wins;
    @(posedge clk_in) disable iff (!rst_n)
      (auto_gate_reg && deep_sleep_req_in) |=> mode_reg == DSG_MODE_DEEP;
  endproperty
  a_deep_wins: assert property (p_deep_wins)                   // [RULE7]
    else $error("deep-sleep request did not select deep gating");

  property p_run_without_auto;
    @(posedge clk_in) disable iff (!rst_n)
      !auto_gate_reg |=> mode_reg == DSG_MODE_RUN;
  endproperty
  a_run_without_auto: assert property (p_run_without_auto)     // [RULE8]
    else $error("mode left run while auto gating is off");

  property p_units_reset;
    @(posedge clk_in) $rose(rst_n) |->
      unit_clk_en_out == dsg_reg_to_units(DSG_GATE_RESET);
  endproperty
  a_units_reset: assert property (p_units_reset)               // [RULE5]
    else $error("unit clocked straight after reset");

  property p_gate_reserved_zero;
    @(posedge clk_in) disable iff (!rst_n)
      ((run_gate_reg | sleep_gate_reg) & ~DSG_GATE_WMASK) == 32'h0000_0000;
  endproperty
  a_gate_reserved_zero: assert property (p_gate_reserved_zero) // [RULE11]
    else $error("reserved run or sleep gating bit is set");

  // Event and clear in one cycle: the event must survive
  property p_fault_sets_status;
    @(posedge clk_in) disable iff (!rst_n)
      fault_pulse |=> irq_status_reg[DSG_IRQ_FAULT];
  endproperty
  a_fault_sets_status: assert property (p_fault_sets_status)   // [RULE4]
    else $error("fault event not recorded in status");

  property p_clear_status;
    @(posedge clk_in) disable iff (!rst_n)
      (wr_w && hit_clear && bus_req_in.wdata[DSG_IRQ_FAULT] && !fault_pulse)
        |=> !irq_status_reg[DSG_IRQ_FAULT];
  endproperty
  a_clear_status: assert property (p_clear_status)
    else $error("fault status bit survived its clear");

  property p_irq_level;
    @(posedge clk_in) disable iff (!rst_n)
      (|(irq_status_reg & irq_enable_reg) && !(wr_w && hit_clear))
        |=> irq_out;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("enabled status bit set but interrupt low");

  property p_clear_reads_zero;
    @(posedge clk_in) disable iff (!rst_n)
      (rd_w && hit_clear) |=> rdata_out == 32'h0000_0000;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero)
    else $error("write-only clear register read back non-zero");

endmodule : dsg_gate_ctl
`default_nettype wire

// *** tb/dsg_unit_model.sv ***
// Behavioural model of the gated peripheral units at the far side
`timescale 1ns/10ps
`default_nettype none
module dsg_unit_model
  import dsg_pkg::*;
(
  input  wire logic       clk_in,
  input  wire dsg_units_t clk_en_in,
  input  wire dsg_units_t req_in,
  output var  dsg_units_t access_out,
  output var  dsg_units_t tick_out
);
  // ==========================================================================
  // Units decode a bus access only in the cycle it is presented
  assign access_out = req_in;

  // ==========================================================================
  // Each unit toggles its activity bit only on cycles it is clocked
  initial tick_out = '0;
  always @(posedge clk_in) begin
    tick_out <= tick_out ^ clk_en_in;
  end
endmodule : dsg_unit_model
`default_nettype wire

// *** tb/deep_sleep_clock_gate_ctl_tb_top.sv ***
// Self-checking testbench of the clock gate control block
`timescale 1ns/10ps
`default_nettype none
module deep_sleep_clock_gate_ctl_tb_top;
  import dsg_pkg::*;
  logic         clk_in;
  logic         rstn_in;
  dsg_bus_req_t bus_req;
  logic [31:0]  rdata;
  logic         sleep_req;
  logic         deep_req;
  dsg_units_t   acc_req;
  dsg_units_t   access;
  dsg_units_t   clk_en;
  dsg_units_t   ticks;
  dsg_units_t   prev;
  logic         fault;
  logic         irq;
  dsg_mode_t    mode;
  int           err_total;
  int           n_compared;
  logic [31:0]  d;
  logic [31:0]  r_run;
  logic [31:0]  r_slp;
  logic [31:0]  r_deep;

  always #10 clk_in = ~clk_in;

  dsg_gate_ctl u_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .bus_req_in(bus_req),
    .rdata_out(rdata), .sleep_req_in(sleep_req),
    .deep_sleep_req_in(deep_req), .unit_access_in(access),
    .unit_clk_en_out(clk_en), .bus_fault_out(fault), .mode_out(mode),
    .irq_out(irq)
  );

  dsg_unit_model u_units (
    .clk_in(clk_in), .clk_en_in(clk_en), .req_in(acc_req),
    .access_out(access), .tick_out(ticks)
  );

  // ==========================================================================
  // Expectation and bus helpers
  function automatic dsg_units_t units_of(input logic [31:0] r);
    return {r[25], r[24], r[18], r[17], r[16], r[4], r[0]};
  endfunction : units_of

  task automatic check(input string w, input logic [31:0] s,
                       input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_in);
    bus_req.addr  <= a;
    bus_req.wdata <= v;
    bus_req.wr    <= 1'b1;
    @(posedge clk_in);
    bus_req.wr    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input string w);
    @(posedge clk_in);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk_in);
    bus_req.rd   <= 1'b0;
    #1 check(w, rdata, e);
  endtask : rd_chk

  // Enables reach the units two edges after the cause
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic mode_chk(input logic s, input logic dp,
                          input logic [31:0] r, input dsg_mode_t m);
    @(posedge clk_in);
    sleep_req <= s;
    deep_req  <= dp;
    settle();
    check("unit_clk_en", clk_en, units_of(r));
    check("mode", mode, m);
  endtask : mode_chk

  // Access one unit, fault expected two edges after the access is taken
  task automatic poke(input int i, input logic e);
    @(posedge clk_in);
    acc_req <= dsg_units_t'(7'h01 << i);
    @(posedge clk_in);
    acc_req <= '0;
    #1 check("early_fault", fault, 1'b0);
    @(posedge clk_in);
    #1 check("bus_fault", fault, e);
    @(posedge clk_in);
    #1 check("fault_drop", fault, 1'b0);
  endtask : poke

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Watchdog so a stuck sequence still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    print_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    clk_in = 1'b0;
    rstn_in = 1'b0;
    bus_req = '0;
    sleep_req = 1'b0;
    deep_req = 1'b0;
    acc_req = '0;
    err_total = 0;
    n_compared = 0;
    d = $urandom(32'h9C34);
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    settle();
    check("reset_en", clk_en, 7'h00);
    check("reset_mode", mode, DSG_MODE_RUN);
    rd_chk(DSG_OFS_DEEP_GATE, 32'h0000_0000, "deep_rst");
    rd_chk(DSG_OFS_RUN_GATE, 32'h0000_0000, "run_rst");
    rd_chk(DSG_OFS_SLEEP_GATE, 32'h0000_0000, "slp_rst");
    wr(DSG_OFS_DEEP_GATE, 32'hFFFF_FFFF);
    rd_chk(DSG_OFS_DEEP_GATE, 32'h0307_0011, "deep_ones");
    wr(12'h128, 32'h0000_0000);
    rd_chk(12'h128, 32'h0000_0000, "unmapped");
    rd_chk(DSG_OFS_DEEP_GATE, 32'h0307_0011, "deep_kept");
    for (int i = 0; i < 8; i++) begin
      d = $urandom();
      wr(DSG_OFS_DEEP_GATE, d);
      rd_chk(DSG_OFS_DEEP_GATE, d & DSG_GATE_WMASK, "deep_rnd");
    end
    // Distinct images so a wrong register selection is visible
    r_run = $urandom() & DSG_GATE_WMASK;
    r_slp = r_run ^ 32'h0100_0010;
    r_deep = r_run ^ 32'h0206_0001;
    wr(DSG_OFS_RUN_GATE, r_run);
    wr(DSG_OFS_SLEEP_GATE, r_slp);
    wr(DSG_OFS_DEEP_GATE, r_deep);
    mode_chk(1'b0, 1'b1, r_run, DSG_MODE_RUN);
    mode_chk(1'b1, 1'b0, r_run, DSG_MODE_RUN);
    wr(DSG_OFS_RUN_CFG, 32'h0000_0001);
    mode_chk(1'b1, 1'b1, r_deep, DSG_MODE_DEEP);
    mode_chk(1'b1, 1'b0, r_slp, DSG_MODE_SLEEP);
    mode_chk(1'b0, 1'b0, r_run, DSG_MODE_RUN);
    rd_chk(DSG_OFS_IRQ_STATUS, 32'h0000_0002, "mode_event");
    prev = ticks;
    @(posedge clk_in);
    #1 check("unit_ticks", ticks ^ prev, units_of(r_run));
    // Fault path: only the async serial unit is clocked
    wr(DSG_OFS_IRQ_CLEAR, 32'h0000_0003);
    wr(DSG_OFS_RUN_GATE, 32'h0000_0001);
    settle();
    check("irq_idle", irq, 1'b0);
    poke(1, 1'b1);
    #20 check("irq_masked", irq, 1'b0);
    wr(DSG_OFS_IRQ_ENABLE, 32'h0000_0001);
    settle();
    check("irq_on", irq, 1'b1);
    wr(DSG_OFS_IRQ_CLEAR, 32'h0000_0001);
    settle();
    check("irq_clr", irq, 1'b0);
    for (int i = 0; i < 7; i++) begin
      poke(i, i != 0);
    end
    rd_chk(DSG_OFS_FAULT_INFO, 32'h0000_0040, "fault_unit");
    rd_chk(DSG_OFS_IRQ_STATUS, 32'h0000_0001, "fault_event");
    check("irq_fault", irq, 1'b1);
    print_verdict();
  end
endmodule : deep_sleep_clock_gate_ctl_tb_top
`default_nettype wire
